// *** logic/acd_top.sv ***
/*
  Audio clock dividers: PCM clock with integer and fractional
  division, PDM clock with master or slave role, and the sample
  rate converter clock, all programmed over APB.
  Assumes pclk is the source clock and every input is synchronous to it.
*/
`timescale 1ns/10ps
module acd_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acd_pkg::ADDR_W-1:0] paddr,
  input wire logic [acd_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [acd_pkg::DATA_W-1:0] prdata,
  // Audio clocks
  output logic pcm_clk,
  output logic src_clk,
  output logic pdm_clk,
  // PDM clock pin
  input wire logic pdm_clk_in,
  output logic pdm_clk_out,
  output logic pdm_clk_oe
);
  import acd_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  function automatic logic [4:0] top_plus_one(input logic [15:0] f);
    top_plus_one = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (f[i]) begin
        top_plus_one = 5'(i + 1);
      end
    end
  endfunction

  function automatic logic [4:0] ones_count(input logic [15:0] f);
    ones_count = 5'h00;
    for (int i = 0; i < 16; i++) begin
      ones_count = ones_count + {4'h0, f[i]};
    end
  endfunction

  // Half period in source cycles; zero behaves like one
  function automatic logic [11:0] half_lim(input logic [11:0] d);
    half_lim = (d == 12'h000) ? 12'h000 : d - 12'h001;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [PCM_REG_W-1:0] pcm_ctrl_reg;
  logic [FRAC_W-1:0] frac_reg;
  logic [PDM_REG_W-1:0] pdm_ctrl_reg;
  logic [SRC_REG_W-1:0] src_ctrl_reg;
  logic [PCM_DIV_W-1:0] pcm_lat_reg;
  logic [DIV8_W-1:0] pdm_lat_reg;
  logic [DIV8_W-1:0] src_lat_reg;

  logic setup_ph;
  logic wr_acc;
  logic sel_pcm;
  logic sel_frac;
  logic sel_pdm;
  logic sel_src;
  logic sel_stat;
  logic [15:0] pcm_wv;
  logic [15:0] pdm_wv;
  logic [15:0] src_wv;
  logic [4:0] frac_den;
  logic [4:0] frac_num;
  logic [DATA_W-1:0] rd_next;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign sel_pcm = paddr == acd_byte_addr(PCM_DIV_IDX);
  assign sel_frac = paddr == acd_byte_addr(PCM_FRAC_IDX);
  assign sel_pdm = paddr == acd_byte_addr(PDM_CTRL_IDX);
  assign sel_src = paddr == acd_byte_addr(SRC_CTRL_IDX);
  assign sel_stat = paddr == acd_byte_addr(STATUS_IDX);
  assign pcm_wv = merge16({2'h0, pcm_ctrl_reg}, pwdata, pstrb);
  assign pdm_wv = merge16({6'h00, pdm_ctrl_reg}, pwdata, pstrb);
  assign src_wv = merge16({7'h00, src_ctrl_reg}, pwdata, pstrb);
  assign frac_den = top_plus_one(frac_reg);
  assign frac_num = ones_count(frac_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_ctrl_reg <= PCM_REG_RST;
      frac_reg <= FRAC_REG_RST;
      pdm_ctrl_reg <= PDM_REG_RST;
      src_ctrl_reg <= SRC_REG_RST;
    end else if (wr_acc) begin
      if (sel_pcm) begin
        pcm_ctrl_reg <= pcm_wv[PCM_REG_W-1:0];
      end
      if (sel_frac) begin
        frac_reg <= merge16(frac_reg, pwdata, pstrb);
      end
      if (sel_pdm) begin
        pdm_ctrl_reg <= pdm_wv[PDM_REG_W-1:0];
      end
      if (sel_src) begin
        src_ctrl_reg <= src_wv[SRC_REG_W-1:0];
      end
    end
  end

  // Divisors are captured only as a gate opens, so a later rewrite
  // of the divisor field leaves a running clock undisturbed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_lat_reg <= '0;
      pdm_lat_reg <= '0;
      src_lat_reg <= '0;
    end else if (wr_acc) begin
      if (sel_pcm && !pcm_ctrl_reg[PCM_GATE_BIT] && pcm_wv[PCM_GATE_BIT]) begin
        pcm_lat_reg <= pcm_wv[PCM_DIV_W-1:0];
      end
      if (sel_pdm && !pdm_ctrl_reg[PDM_GATE_BIT] && pdm_wv[PDM_GATE_BIT]) begin
        pdm_lat_reg <= pdm_wv[DIV8_W-1:0];
      end
      if (sel_src && !src_ctrl_reg[SRC_GATE_BIT] && src_wv[SRC_GATE_BIT]) begin
        src_lat_reg <= src_wv[DIV8_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // APB answer: no wait state, data from flops
  // ----------------------------------------
  always_comb begin
    rd_next = '0;
    if (sel_pcm) begin
      rd_next = {18'h00000, pcm_ctrl_reg};
    end else if (sel_frac) begin
      rd_next = {16'h0000, frac_reg};
    end else if (sel_pdm) begin
      rd_next = {22'h000000, pdm_ctrl_reg};
    end else if (sel_src) begin
      rd_next = {23'h000000, src_ctrl_reg};
    end else if (sel_stat) begin
      rd_next[STAT_NUM_LSB +: 5] = frac_num;
      rd_next[STAT_DEN_LSB +: 5] = frac_den;
      rd_next[STAT_RUN_LSB +: 3] = {src_clk, pdm_clk, pcm_clk};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (setup_ph) begin
      pready <= 1'b1;
      pslverr <= !(sel_pcm || sel_frac || sel_pdm || sel_src || sel_stat);
      prdata <= pwrite ? '0 : rd_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // PCM divider with fractional stretch
  // ----------------------------------------
  logic [11:0] pcm_cnt_reg;
  logic [3:0] pcm_pos_reg;
  logic pcm_ext_reg;
  logic [11:0] pcm_lim;
  logic [3:0] frac_top;

  assign pcm_lim = half_lim(pcm_lat_reg);
  assign frac_top = (frac_den == 5'h00) ? 4'h0 : 4'(frac_den - 5'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_cnt_reg <= '0;
      pcm_pos_reg <= '0;
      pcm_ext_reg <= 1'b0;
      pcm_clk <= 1'b0;
    end else if (!pcm_ctrl_reg[PCM_GATE_BIT]) begin
      pcm_cnt_reg <= '0;
      pcm_pos_reg <= frac_top;
      pcm_ext_reg <= 1'b0;
      pcm_clk <= 1'b0;
    end else if (pcm_cnt_reg != pcm_lim) begin
      pcm_cnt_reg <= pcm_cnt_reg + 12'h001;
    end else if (!pcm_clk && pcm_ext_reg) begin
      pcm_ext_reg <= 1'b0;
    end else begin
      pcm_cnt_reg <= '0;
      pcm_clk <= !pcm_clk;
      if (!pcm_clk) begin
        // A cycle starts: decide now whether its low phase is stretched
        pcm_ext_reg <= (frac_den != 5'h00) && frac_reg[pcm_pos_reg];
        pcm_pos_reg <= (pcm_pos_reg == 4'h0) ? frac_top : pcm_pos_reg - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // PDM and converter dividers
  // ----------------------------------------
  logic [7:0] pdm_cnt_reg;
  logic [7:0] src_cnt_reg;
  logic pdm_run;
  logic [11:0] pdm_lim;
  logic [11:0] src_lim;

  assign pdm_run = pdm_ctrl_reg[PDM_GATE_BIT] && pdm_ctrl_reg[PDM_MASTER_BIT];
  assign pdm_lim = half_lim({4'h0, pdm_lat_reg});
  assign src_lim = half_lim({4'h0, src_lat_reg});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdm_cnt_reg <= '0;
      pdm_clk_out <= 1'b0;
    end else if (!pdm_run) begin
      pdm_cnt_reg <= '0;
      pdm_clk_out <= 1'b0;
    end else if ({4'h0, pdm_cnt_reg} != pdm_lim) begin
      pdm_cnt_reg <= pdm_cnt_reg + 8'h01;
    end else begin
      pdm_cnt_reg <= '0;
      pdm_clk_out <= !pdm_clk_out;
    end
  end

  // Slave role follows the pin; the copy lags the source by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdm_clk <= 1'b0;
      pdm_clk_oe <= 1'b0;
    end else begin
      pdm_clk_oe <= pdm_run;
      if (!pdm_ctrl_reg[PDM_GATE_BIT]) begin
        pdm_clk <= 1'b0;
      end else if (pdm_ctrl_reg[PDM_MASTER_BIT]) begin
        pdm_clk <= pdm_clk_out;
      end else begin
        pdm_clk <= pdm_clk_in;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_cnt_reg <= '0;
      src_clk <= 1'b0;
    end else if (!src_ctrl_reg[SRC_GATE_BIT]) begin
      src_cnt_reg <= '0;
      src_clk <= 1'b0;
    end else if ({4'h0, src_cnt_reg} != src_lim) begin
      src_cnt_reg <= src_cnt_reg + 8'h01;
    end else begin
      src_cnt_reg <= '0;
      src_clk <= !src_clk;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Low phase counted out while one extra source cycle is still owed
  sequence pcm_stretch_s;
    pcm_ctrl_reg[PCM_GATE_BIT] && !pcm_clk && pcm_ext_reg && pcm_cnt_reg == pcm_lim;
  endsequence

  sequence pcm_gate_open_s;
    wr_acc && sel_pcm && !pcm_ctrl_reg[PCM_GATE_BIT] && pcm_wv[PCM_GATE_BIT];
  endsequence

  pcm_off_a: assert property (!pcm_ctrl_reg[PCM_GATE_BIT] |=> !pcm_clk)
    else $error("PCM clock active while gate off");
  pcm_latch_a: assert property (pcm_gate_open_s |=> pcm_lat_reg == $past(pwdata[11:0])
                                && pcm_ctrl_reg[PCM_GATE_BIT])
    else $error("PCM divisor not taken at gate enable");
  frac_den_a: assert property ((frac_reg >> frac_den) == 16'h0000
                               && (frac_den == 5'h00 || frac_reg[frac_top]))
    else $error("Fraction denominator wrong");
  frac_num_a: assert property (frac_num == 5'($countones(frac_reg)))
    else $error("Fraction numerator wrong");
  // The owed cycle keeps the clock low once more, then it must rise
  pcm_stretch_a: assert property (pcm_stretch_s |=>
                                  !pcm_clk ##1 (pcm_clk || !pcm_ctrl_reg[PCM_GATE_BIT]))
    else $error("PCM low phase not stretched by one cycle");
  pdm_role_a: assert property (pdm_clk_oe |-> $past(pdm_ctrl_reg[PDM_MASTER_BIT]))
    else $error("PDM pin driven in slave role");
  pdm_off_a: assert property (!pdm_ctrl_reg[PDM_GATE_BIT] [*2] |-> !pdm_clk && !pdm_clk_oe)
    else $error("PDM clock active while gate off");
  pdm_latch_a: assert property (wr_acc && sel_pdm && !pdm_ctrl_reg[PDM_GATE_BIT]
                                && pdm_wv[PDM_GATE_BIT] |=>
                                pdm_lat_reg == $past(pwdata[7:0]))
    else $error("PDM divisor not taken with gate");
  src_off_a: assert property (!src_ctrl_reg[SRC_GATE_BIT] |=> !src_clk)
    else $error("Converter clock active while gate off");
  src_period_a: assert property (src_ctrl_reg[SRC_GATE_BIT] && src_lat_reg == 8'h03
                                 && $rose(src_clk) |-> src_clk [*3]
                                 ##1 (!src_clk || !src_ctrl_reg[SRC_GATE_BIT]))
    else $error("Converter half period wrong");
  reset_zero_a: assert property ($rose(presetn) |-> pcm_ctrl_reg == '0
                                 && pdm_ctrl_reg == '0 && src_ctrl_reg == '0 && !pdm_clk_oe)
    else $error("State not cleared by reset");

endmodule

// *** logic/acd_pkg.sv ***
/*
  Constants for the audio clock divider block: register indices,
  field positions, widths and reset values.
  Assumes a 32-bit APB bus carrying a 12-bit local byte address.
*/
package acd_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [31:0] PCM_DIV_IDX = 32'h50001C40;
  localparam logic [31:0] PCM_FRAC_IDX = 32'h50001C42;
  localparam logic [31:0] PDM_CTRL_IDX = 32'h50001C44;
  localparam logic [31:0] SRC_CTRL_IDX = 32'h50001C46;
  localparam logic [31:0] STATUS_IDX = 32'h50001C48;

  // Local byte address, index times four, cut to the decoded width
  function automatic logic [ADDR_W-1:0] acd_byte_addr(input logic [31:0] idx);
    acd_byte_addr = {idx[ADDR_W-3:0], 2'h0};
  endfunction

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int unsigned PCM_REG_W = 14;
  localparam int unsigned PCM_DIV_W = 12;
  localparam int unsigned PCM_GATE_BIT = 12;
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned PDM_REG_W = 10;
  localparam int unsigned PDM_MASTER_BIT = 9;
  localparam int unsigned PDM_GATE_BIT = 8;
  localparam int unsigned SRC_REG_W = 9;
  localparam int unsigned SRC_GATE_BIT = 8;
  localparam int unsigned DIV8_W = 8;
  localparam int unsigned STAT_NUM_LSB = 0;
  localparam int unsigned STAT_DEN_LSB = 8;
  localparam int unsigned STAT_RUN_LSB = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [PCM_REG_W-1:0] PCM_REG_RST = 14'h0000;
  localparam logic [FRAC_W-1:0] FRAC_REG_RST = 16'h0000;
  localparam logic [PDM_REG_W-1:0] PDM_REG_RST = 10'h000;
  localparam logic [SRC_REG_W-1:0] SRC_REG_RST = 9'h000;

endpackage

// *** testbench/acd_tb.sv ***
/*
  Self-checking bench for the audio clock dividers: APB register
  access, converter, PDM and fractional PCM clock timing.
  Assumes acd_top answers each APB access after one setup cycle.
*/
`timescale 1ns/10ps
module testbench;
  import acd_pkg::*;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pdm_clk_in;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0] pstrb, clks;
  logic pready, pslverr, pcm_clk, src_clk, pdm_clk, pdm_clk_out, pdm_clk_oe, err;
  logic [15:0] pat;
  int failures, tests_run, seed, c, d, top, pv;
  int q[$];
  logic [15:0] msk [4] = '{16'h3FFF, 16'hFFFF, 16'h03FF, 16'h01FF};
  logic [15:0] tbl [4] = '{16'h0110, 16'hFEEE, 16'h8000, 16'h0001};
  logic [11:0] adr [5] = '{{PCM_DIV_IDX[9:0], 2'h0}, {PCM_FRAC_IDX[9:0], 2'h0},
    {PDM_CTRL_IDX[9:0], 2'h0}, {SRC_CTRL_IDX[9:0], 2'h0}, {STATUS_IDX[9:0], 2'h0}};

  assign clks = {pdm_clk, pdm_clk_out, src_clk, pcm_clk};

  acd_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .prdata, .pcm_clk, .src_clk, .pdm_clk, .pdm_clk_in,
    .pdm_clk_out, .pdm_clk_oe);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dt);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles until the next rising edge of one clock output
  task automatic rise(input int k, output int cy);
    logic p;
    cy = 0;
    while (cy < 300) begin
      p = clks[k];
      @(negedge pclk);
      cy++;
      if (p === 1'b0 && clks[k] === 1'b1) break;
    end
    if (cy >= 300) begin
      failures++;
      report_and_stop();
    end
  endtask

  // A stopped clock must show no high level at all
  task automatic quiet(input int k);
    int n;
    n = 0;
    repeat (3) @(negedge pclk);
    repeat (20) begin
      @(negedge pclk);
      n += (clks[k] !== 1'b0);
    end
    check(n, 0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h7648;
    failures = 0;
    tests_run = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    pdm_clk_in = 1'b0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({clks, pdm_clk_oe}, 0);
    for (int i = 0; i < 4; i++) begin
      apb(adr[i], 1'b0, 0);
      check(rd | 32'(err), 0);
    end
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      apb(adr[i], 1'b1, d);
      apb(adr[i], 1'b0, 0);
      check(rd, d & msk[i]);
      apb(adr[i], 1'b1, 0);
    end
    // Byte lanes: only the enabled lane of the pattern may change
    pstrb <= 4'h2;
    apb(adr[1], 1'b1, 32'hA5C3);
    pstrb <= 4'hF;
    apb(adr[1], 1'b0, 0);
    check(rd, 32'hA500);
    apb(12'h0FC, 1'b0, 0);
    check({rd[30:0], err}, 1);
    // Converter clock: divisor only taken when the gate opens
    apb(adr[3], 1'b1, 32'h103);
    rise(1, c);
    rise(1, c);
    check(c, 6);
    apb(adr[3], 1'b1, 32'h105);
    rise(1, c);
    rise(1, c);
    check(c, 6);
    apb(adr[3], 1'b1, 0);
    quiet(1);
    apb(adr[3], 1'b1, 32'h105);
    rise(1, c);
    rise(1, c);
    check(c, 10);
    apb(adr[3], 1'b1, 0);
    // PDM master then slave
    apb(adr[2], 1'b1, 32'h302);
    rise(2, c);
    rise(2, c);
    check({c[30:0], pdm_clk_oe}, 9);
    apb(adr[2], 1'b1, 32'h102);
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      @(posedge pclk);
      pdm_clk_in <= d[0];
      @(negedge pclk);
      if (i > 1) check({pdm_clk, pdm_clk_oe}, {pv[0], 1'b0});
      pv = d;
    end
    apb(adr[2], 1'b1, 0);
    pdm_clk_in <= 1'b1;
    quiet(2);
    quiet(3);
    // PCM fractional patterns
    for (int j = 0; j < 5; j++) begin
      pat = (j < 4) ? tbl[j] : 16'($random(seed) | 1);
      d = 2 + j % 2;
      apb(adr[1], 1'b1, pat);
      top = 0;
      for (int b = 0; b < 16; b++) if (pat[b]) top = b;
      c = $countones(pat);
      apb(adr[4], 1'b0, 0);
      check({rd[12:8], rd[4:0]}, {5'(top + 1), c[4:0]});
      q = {};
      for (int k = 0; k < top + 3; k++) q.push_back(2 * d + pat[top - k % (top + 1)]);
      apb(adr[0], 1'b1, 32'h1000 | d);
      rise(0, c);
      foreach (q[k]) begin
        rise(0, c);
        check(c, q[k]);
      end
      apb(adr[0], 1'b1, 0);
    end
    apb(adr[1], 1'b1, 0);
    apb(adr[0], 1'b1, 32'h1002);
    apb(adr[0], 1'b1, 32'h1007);
    rise(0, c);
    rise(0, c);
    check(c, 4);
    apb(adr[0], 1'b1, 32'h0007);
    quiet(0);
    // Reset in mid-run must stop running clocks and clear every field
    apb(adr[2], 1'b1, 32'h302);
    apb(adr[3], 1'b1, 32'h103);
    repeat (8) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({clks, pdm_clk_oe}, 0);
    for (int i = 0; i < 4; i++) begin
      apb(adr[i], 1'b0, 0);
      check(rd | 32'(err), 0);
    end
    quiet(1);
    quiet(2);
    report_and_stop();
  end
endmodule
